// ===== core/comparator_one_cfg.svh
// Constants for the second comparator's primary control register.
// Assumes inclusion by bare name from files under core/.
`ifndef COMPARATOR_ONE_CFG_SVH
`define COMPARATOR_ONE_CFG_SVH
`define CMP1_CTRL_ADDR 8'hBF
`define CMP1_PAGE_A 8'h00
`define CMP1_PAGE_B 8'h30
`define CMP1_CTRL_RESET 8'h00
`define CMP1_BIT_ON 7
`define CMP1_BIT_RESULT 6
`define CMP1_BIT_RISE 5
`define CMP1_BIT_FALL 4
`define CMP1_HYP_HI 3
`define CMP1_HYP_LO 2
`define CMP1_HYN_HI 1
`define CMP1_HYN_LO 0
`define CMP1_SYNC_STAGES 2
`endif

// ===== core/comparator_one_pkg.sv
// Types for the second comparator's control register.
// Assumes comparator_one_cfg.svh is compiled alongside.
package comparator_one_pkg;
   // Hysteresis level code
   typedef enum logic [1:0] {
      HYST_OFF = 2'h0,
      HYST_ONE = 2'h1,
      HYST_TWO = 2'h2,
      HYST_MAX = 2'h3
   } hyst_t;
   // Special-function bus request
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sfr_req_t;
   // Settings toward the analog core
   typedef struct packed {
      logic on;
      hyst_t pos_hyst;
      hyst_t neg_hyst;
   } analog_ctl_t;
endpackage : comparator_one_pkg

// ===== core/level_sync.sv
// Two-flop synchroniser for a level arriving from the analog core.
// Assumes the input is asynchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module level_sync (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Level in and out
   input wire logic async_in,
   output logic sync_out
);
   logic stage_a;
   logic next_stage_a;
   logic next_sync_out;

   ////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second
   always_comb begin
      next_stage_a = async_in;
      next_sync_out = stage_a;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stage_a <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage_a <= next_stage_a;
         sync_out <= next_sync_out;
      end
   end
endmodule : level_sync
`default_nettype wire

// ===== core/comparator_one_control_reg.sv
// Primary control and status register of the second analog comparator.
// Assumes a single-cycle special-function bus on ref_clk and a raw
// comparator result that is asynchronous to that clock.
//
// How it works
// (R1) Register sits at address BF, reachable on page 00 and page 30.
// (R2) Bit 6 mirrors the live result, ignores writes, reads zero after reset.
// (R3) Result reads 1 when enabled and plus input exceeds minus input, 0 when minus exceeds plus or disabled.
// (R4) Bit 5 sets on every low-to-high change of the result.
// (R5) Rise flag stays set until software writes zero; hardware never clears.
// (R6) Bit 4 sets on each high-to-low change while enabled and stays until cleared.
// (R7) Bits 3:2 choose positive hysteresis: off, level one, two, maximum.
// (R8) Bits 1:0 choose negative hysteresis: off, level one, two, maximum.
// (R9) Bit 7 enables the comparator; while zero no edge events occur.
`timescale 1ns/10ps
`default_nettype none
`include "comparator_one_cfg.svh"
module comparator_one_control_reg (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Special-function bus
   input wire comparator_one_pkg::sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   // Analog comparator core
   input wire logic raw_result,
   output comparator_one_pkg::analog_ctl_t analog_ctl
);
   logic result_sync;
   logic result_prev;
   logic next_result_prev;
   logic comparator_on;
   logic next_comparator_on;
   logic rise_seen_flag;
   logic next_rise_seen_flag;
   logic fall_seen_flag;
   logic next_fall_seen_flag;
   logic [1:0] positive_hyst_select;
   logic [1:0] next_positive_hyst_select;
   logic [1:0] negative_hyst_select;
   logic [1:0] next_negative_hyst_select;
   logic [7:0] next_sfr_rdata;
   logic next_sfr_hit;
   comparator_one_pkg::analog_ctl_t next_analog_ctl;
   logic sel;
   logic wr_hit;
   logic rise_evt;
   logic fall_evt;
   logic comparator_result;

   // Address match on either page
   function automatic logic page_match(input logic [7:0] page,
                                       input logic [7:0] addr);
      page_match = (addr == `CMP1_CTRL_ADDR) &&
                   (page == `CMP1_PAGE_A || page == `CMP1_PAGE_B);
   endfunction : page_match

   ////////////////////////////////////////////////////////////////////////
   // Result from the analog core crosses in through two flops
   level_sync u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in(raw_result),
      .sync_out(result_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decode and event detect
   always_comb begin
      sel = page_match(sfr_req.page, sfr_req.addr); // R1
      wr_hit = sel && sfr_req.wr;
      // Disabled comparator reads low and makes no edges
      comparator_result = comparator_on & result_sync; // R3 R9
      // Gating by the enable stops a disable from faking a falling edge
      rise_evt = comparator_on && comparator_result && !result_prev; // R4
      fall_evt = comparator_on && !comparator_result && result_prev; // R6 R9
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state of the register fields; a set beats a same-cycle clear
   always_comb begin
      next_result_prev = comparator_result;
      next_comparator_on = comparator_on;
      next_rise_seen_flag = rise_seen_flag;
      next_fall_seen_flag = fall_seen_flag;
      next_positive_hyst_select = positive_hyst_select;
      next_negative_hyst_select = negative_hyst_select;
      if (wr_hit) begin
         next_comparator_on = sfr_req.wdata[`CMP1_BIT_ON]; // R9
         next_rise_seen_flag = sfr_req.wdata[`CMP1_BIT_RISE]; // R5
         next_fall_seen_flag = sfr_req.wdata[`CMP1_BIT_FALL]; // R6
         next_positive_hyst_select =
            sfr_req.wdata[`CMP1_HYP_HI:`CMP1_HYP_LO]; // R7
         next_negative_hyst_select =
            sfr_req.wdata[`CMP1_HYN_HI:`CMP1_HYN_LO]; // R8
      end
      if (rise_evt) begin
         next_rise_seen_flag = 1'b1; // R4
      end
      if (fall_evt) begin
         next_fall_seen_flag = 1'b1; // R6
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data and analog settings, registered so outputs come from flops
   always_comb begin
      next_sfr_hit = sel && (sfr_req.rd || sfr_req.wr);
      next_sfr_rdata = 8'h00;
      if (sel && sfr_req.rd) begin
         next_sfr_rdata = {comparator_on, comparator_result, // R2
                           rise_seen_flag, fall_seen_flag,
                           positive_hyst_select, negative_hyst_select};
      end
      next_analog_ctl.on = next_comparator_on;
      next_analog_ctl.pos_hyst =
         comparator_one_pkg::hyst_t'(next_positive_hyst_select); // R7
      next_analog_ctl.neg_hyst =
         comparator_one_pkg::hyst_t'(next_negative_hyst_select); // R8
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         result_prev <= 1'b0;
         comparator_on <= 1'b0;
         rise_seen_flag <= 1'b0;
         fall_seen_flag <= 1'b0;
         positive_hyst_select <= 2'h0;
         negative_hyst_select <= 2'h0;
         sfr_rdata <= `CMP1_CTRL_RESET;
         sfr_hit <= 1'b0;
         analog_ctl <= '0;
      end else begin
         result_prev <= next_result_prev;
         comparator_on <= next_comparator_on;
         rise_seen_flag <= next_rise_seen_flag;
         fall_seen_flag <= next_fall_seen_flag;
         positive_hyst_select <= next_positive_hyst_select;
         negative_hyst_select <= next_negative_hyst_select;
         sfr_rdata <= next_sfr_rdata;
         sfr_hit <= next_sfr_hit;
         analog_ctl <= next_analog_ctl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_rise;
      comparator_on && comparator_result && !result_prev;
   endsequence
   sequence s_fall;
      comparator_on && !comparator_result && result_prev;
   endsequence

   property p_page_alias;
      @(posedge ref_clk) disable iff (sys_rst)
      (sfr_req.rd && sfr_req.addr == `CMP1_CTRL_ADDR &&
       (sfr_req.page == `CMP1_PAGE_A || sfr_req.page == `CMP1_PAGE_B))
      |=> sfr_hit;
   endproperty
   a_page_alias: assert property (p_page_alias) // R1
      else $error("register not answered on page");

   property p_result_ro;
      @(posedge ref_clk) disable iff (sys_rst)
      (sfr_req.rd && sel) |=> sfr_rdata[6] == $past(comparator_result);
   endproperty
   a_result_ro: assert property (p_result_ro) // R2
      else $error("result bit not live");

   property p_off_low;
      @(posedge ref_clk) disable iff (sys_rst)
      (sel && sfr_req.rd && !comparator_on) |=>
         !sfr_rdata[`CMP1_BIT_RESULT];
   endproperty
   a_off_low: assert property (p_off_low) // R3
      else $error("result high while disabled");

   property p_rise_set;
      @(posedge ref_clk) disable iff (sys_rst)
      s_rise |=> rise_seen_flag;
   endproperty
   a_rise_set: assert property (p_rise_set) // R4
      else $error("rise flag not set");

   property p_rise_sticky;
      @(posedge ref_clk) disable iff (sys_rst)
      (rise_seen_flag && !wr_hit) |=> rise_seen_flag;
   endproperty
   a_rise_sticky: assert property (p_rise_sticky) // R5
      else $error("rise flag lost");

   property p_fall_set;
      @(posedge ref_clk) disable iff (sys_rst)
      s_fall |=> fall_seen_flag;
   endproperty
   a_fall_set: assert property (p_fall_set) // R6
      else $error("fall flag not set");

   property p_fall_sticky;
      @(posedge ref_clk) disable iff (sys_rst)
      (fall_seen_flag && !wr_hit) |=> fall_seen_flag;
   endproperty
   a_fall_sticky: assert property (p_fall_sticky) // R6
      else $error("fall flag lost");

   property p_hyp_write;
      @(posedge ref_clk) disable iff (sys_rst)
      wr_hit |=> analog_ctl.pos_hyst == $past(sfr_req.wdata[3:2]);
   endproperty
   a_hyp_write: assert property (p_hyp_write) // R7
      else $error("positive hysteresis not applied");

   property p_hyn_write;
      @(posedge ref_clk) disable iff (sys_rst)
      wr_hit |=> negative_hyst_select == $past(sfr_req.wdata[1:0]);
   endproperty
   a_hyn_write: assert property (p_hyn_write) // R8
      else $error("negative hysteresis not stored");

   property p_no_edge_off;
      @(posedge ref_clk) disable iff (sys_rst)
      (!comparator_on && !wr_hit) |=>
         $stable(rise_seen_flag) && $stable(fall_seen_flag);
   endproperty
   a_no_edge_off: assert property (p_no_edge_off) // R9
      else $error("edge while disabled");
endmodule : comparator_one_control_reg
`default_nettype wire

// ===== verif/comparator_one_analog_model.sv
// Behavioural analog front end of the second comparator.
// Assumes the bench drives both input levels.
`timescale 1ns/10ps
`default_nettype none
module comparator_one_analog_model (
   // Input levels
   input wire logic [7:0] plus_input,
   input wire logic [7:0] minus_input,
   // Raw decision, asynchronous to the bus clock
   output logic raw_result
);
   // Equal levels keep the old decision, so no forced value there
   initial begin
      raw_result = 1'b0;
      forever begin
         @(plus_input or minus_input);
         if (plus_input != minus_input) begin
            raw_result <= #7 (plus_input > minus_input);
         end
      end
   end
endmodule : comparator_one_analog_model
`default_nettype wire

// ===== verif/comparator_one_control_reg_tb_top.sv
// Self-checking bench for the comparator control register.
// Assumes the analog model is compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module comparator_one_control_reg_tb_top;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   comparator_one_pkg::sfr_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic sfr_hit;
   logic raw_result;
   comparator_one_pkg::analog_ctl_t analog_ctl;
   logic [7:0] plus_v = 8'h10;
   logic [7:0] minus_v = 8'h80;
   logic [7:0] d;
   logic h;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   int i;
   integer seed = 32'h8999;
   // Reference state of the register
   int m_on, m_res, m_rise, m_fall, m_hyp, m_hyn;
   ////////////////////////////////////////////////////////////////////////
   // Clock and the two parties
   always #25 ref_clk = ~ref_clk;
   comparator_one_control_reg dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .raw_result(raw_result), .analog_ctl(analog_ctl));
   comparator_one_analog_model front (.plus_input(plus_v),
      .minus_input(minus_v), .raw_result(raw_result));
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   // A hang counts as a mismatch
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One strobe cycle; answer sampled after the next edge has landed
   task automatic access(input logic [7:0] pg, input logic [7:0] ad,
         input logic w, input logic [7:0] wd);
      @(posedge ref_clk);
      sfr_req <= '{page: pg, addr: ad, wr: w, rd: !w, wdata: wd};
      @(posedge ref_clk);
      sfr_req.wr <= 1'b0;
      sfr_req.rd <= 1'b0;
      #1;
      d = sfr_rdata;
      h = sfr_hit;
   endtask : access
   // Sync lag plus flag edge is three cycles; five leaves margin
   task automatic settle();
      int r;
      repeat (5) @(posedge ref_clk);
      r = m_on && (plus_v > minus_v);
      if (r && !m_res) m_rise = 1;
      if (m_on && !r && m_res) m_fall = 1;
      m_res = r;
   endtask : settle
   task automatic rd_check(input logic [7:0] pg, input logic [7:0] ad,
         input logic eh);
      access(pg, ad, 1'b0, 8'h00);
      check({7'h00, h}, {7'h00, eh});
      check(d, eh ? {m_on[0], m_res[0], m_rise[0], m_fall[0],
         m_hyp[1:0], m_hyn[1:0]} : 8'h00);
   endtask : rd_check
   task automatic wr_reg(input logic [7:0] pg, input logic [7:0] wd);
      access(pg, 8'hBF, 1'b1, wd);
      if (pg == 8'h00 || pg == 8'h30) begin
         m_on = wd[7];
         m_rise = wd[5];
         m_fall = wd[4];
         m_hyp = wd[3:2];
         m_hyn = wd[1:0];
      end
      settle();
      check({3'h0, analog_ctl}, {3'h0, m_on[0], m_hyp[1:0], m_hyn[1:0]});
   endtask : wr_reg
   task automatic levels(input logic [7:0] p, input logic [7:0] n);
      @(posedge ref_clk);
      plus_v <= p;
      minus_v <= n;
      settle();
   endtask : levels
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {m_on, m_res, m_rise, m_fall, m_hyp, m_hyn} = '0;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_check(8'h00, 8'hBF, 1'b1);
      check({3'h0, analog_ctl}, 8'h00);
      // Every code pair, bit 6 forced high, alternate pages
      for (i = 0; i < 16; i++) begin
         wr_reg(i[0] ? 8'h30 : 8'h00, {4'h4, i[3:0]});
         rd_check(i[0] ? 8'h00 : 8'h30, 8'hBF, 1'b1);
      end
      // Disabled: swings must leave both flags clear
      for (i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         levels(d, ~d);
      end
      rd_check(8'h00, 8'hBF, 1'b1);
      levels(8'h10, 8'h80);
      wr_reg(8'h30, 8'h85);
      levels(8'h90, 8'h80);
      levels(8'hA0, 8'h80);
      rd_check(8'h00, 8'hBF, 1'b1);
      levels(8'h20, 8'h80);
      rd_check(8'h30, 8'hBF, 1'b1);
      wr_reg(8'h00, 8'h85);
      rd_check(8'h00, 8'hBF, 1'b1);
      // Random levels, odd plus never equals minus
      for (i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         levels({d[7:1], 1'b1}, 8'h80);
         rd_check(8'h30, 8'hBF, 1'b1);
         wr_reg(8'h00, {4'h8, d[3:0]});
      end
      wr_reg(8'h30, 8'hB0);
      rd_check(8'h00, 8'hBF, 1'b1);
      // Disabling while the result is high must not raise the fall flag
      levels(8'hF1, 8'h80);
      wr_reg(8'h00, 8'h00);
      rd_check(8'h30, 8'hBF, 1'b1);
      // Wrong address or page is not this register
      rd_check(8'h00, 8'h9F, 1'b0);
      rd_check(8'h10, 8'hBF, 1'b0);
      wr_reg(8'h10, 8'h0F);
      rd_check(8'h30, 8'hBF, 1'b1);
      report_and_stop();
   end
endmodule : comparator_one_control_reg_tb_top
`default_nettype wire
